// >>> hw/asp_pkg.sv
// Purpose: Constants and types for the sample post-processing path
// Assumes: Byte-wide register port, one sample per convert strobe
// Notes:   Every register offset and register reset value lives here, with the main widths and the flag bit positions
package asp_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ASP_DIFF_W = 24;
  localparam int ASP_CM_W   = 8;
  localparam int ASP_WORD_W = 32;
  localparam int ASP_GAIN_W = 16;
  localparam int ASP_AVG_W  = 30;
  localparam int ASP_EXP_W  = 5;
  localparam int ASP_ACC_W  = 40;
  localparam int ASP_CNT_W  = 16;
  localparam int ASP_ADDR_W = 8;
  localparam int ASP_DATA_W = 8;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ASP_ADDR_OFS_B0  = 8'h16;
  localparam logic [7:0] ASP_ADDR_OFS_B1  = 8'h17;
  localparam logic [7:0] ASP_ADDR_OFS_B2  = 8'h18;
  localparam logic [7:0] ASP_ADDR_GAIN_A  = 8'h1C;
  localparam logic [7:0] ASP_ADDR_GAIN_B  = 8'h1D;
  localparam logic [7:0] ASP_ADDR_PAT_B0  = 8'h20;
  localparam logic [7:0] ASP_ADDR_PAT_B1  = 8'h21;
  localparam logic [7:0] ASP_ADDR_PAT_B2  = 8'h22;
  localparam logic [7:0] ASP_ADDR_PAT_B3  = 8'h23;
  localparam logic [7:0] ASP_ADDR_MODE    = 8'h24;
  localparam logic [7:0] ASP_ADDR_AVG     = 8'h25;
  localparam logic [7:0] ASP_ADDR_STATUS  = 8'h26;

  // ---------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------
  localparam logic [23:0] ASP_OFS_RST  = 24'h000000;
  localparam logic [15:0] ASP_GAIN_RST = 16'h8000;
  localparam logic [31:0] ASP_PAT_RST  = 32'h5A5A0F0F;
  localparam logic [4:0]  ASP_AVG_RST  = 5'h00;
  localparam logic [4:0]  ASP_EXP_MIN  = 5'h01;
  localparam logic [4:0]  ASP_EXP_MAX  = 5'h10;
  localparam logic [23:0] ASP_SAT_MAX  = 24'h7FFFFF;
  localparam logic [23:0] ASP_SAT_MIN  = 24'h800000;
  localparam int          ASP_GAIN_SH  = 15;
  localparam int          ASP_AVG_EXT  = ASP_AVG_W - ASP_DIFF_W;

  // ---------------------------------------------------------------
  // Output word field positions
  // ---------------------------------------------------------------
  localparam int ASP_SYNC_BIT = 31;
  localparam int ASP_OR_BIT   = 30;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ASP_FMT_D24   = 3'b000,
    ASP_FMT_D16CM = 3'b001,
    ASP_FMT_D24CM = 3'b010,
    ASP_FMT_AVG   = 3'b011,
    ASP_FMT_PAT   = 3'b100
  } asp_fmt_t;

  localparam asp_fmt_t ASP_MODE_RST = ASP_FMT_D24;

  typedef struct packed {
    logic [ASP_DIFF_W-1:0] diff;
    logic [ASP_CM_W-1:0]   cm;
    logic                  sat;
  } asp_sample_t;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [ASP_ADDR_W-1:0] addr;
    logic [ASP_DATA_W-1:0] wdata;
  } asp_reg_req_t;

endpackage : asp_pkg

// >>> hw/asp_post_proc.sv
// Purpose: Offset, gain, saturation, block averaging and output formatting
// Assumes: Converter core strobes only while conv_ready_o is high
// Notes:   Results leave through a two-entry buffer toward the serial side
//
// Operation
// - Average blocks of 2^N samples, N 1..16
// - Clear accumulator after every completed block
// - Averaging only with format 3, N 1..16
// - Averaged word 32 bits, low 30 average
// - Constant input gives top 24 equal input
// - Bit 30 flags saturation within block
// - Bit 31 marks each delivered block average
// - Averaged output rate is strobe rate/2^N
// - Averaging exponent resets to zero
// - Add signed 24-bit offset to every sample
// - Offset resets to zero
// - Multiply by gain over 0x8000
// - Gain resets to 0x8000, unity
// - Saturate scaled results to output width
// - Format 4 outputs stored test pattern
// - Test pattern uses ordinary sample timing
// - Test pattern resets 0x5A5A0F0F, host writable
// - Clamp at 0x7FFFFF and 0x800000
// - Formats 1,2 append unscaled common-mode code
// - Differential codes are two's complement
`timescale 1ns/10ps

module asp_post_proc
(
  // Clock and reset
  input  wire logic                           clk_sys_i,
  input  wire logic                           rst_n_i,
  // Converter core side
  input  wire logic                           convert_strobe_i,
  input  wire asp_pkg::asp_sample_t           sample_i,
  output logic                                conv_ready_o,
  // Register port
  input  wire asp_pkg::asp_reg_req_t          reg_req_i,
  output logic [asp_pkg::ASP_DATA_W-1:0]      reg_rdata_o,
  // Output word toward the serial output register
  output logic [asp_pkg::ASP_WORD_W-1:0]      out_word_o,
  output logic                                out_valid_o,
  input  wire logic                           out_ready_i
);
  import asp_pkg::*;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [ASP_DIFF_W-1:0] ofs_val;
  logic [ASP_GAIN_W-1:0] gain_val;
  logic [ASP_WORD_W-1:0] pat_val;
  asp_fmt_t              fmt_sel;
  logic [ASP_EXP_W-1:0]  avg_exp;
  logic                  cfg_wr;

  // Rewriting format or exponent restarts the block
  assign cfg_wr = reg_req_i.wr &&
                  (reg_req_i.addr == ASP_ADDR_MODE ||
                   reg_req_i.addr == ASP_ADDR_AVG);

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ofs_val  <= ASP_OFS_RST;
      gain_val <= ASP_GAIN_RST;
      pat_val  <= ASP_PAT_RST;
      fmt_sel  <= ASP_MODE_RST;
      avg_exp  <= ASP_AVG_RST;
    end
    else if (reg_req_i.wr)
    begin
      if (reg_req_i.addr == ASP_ADDR_OFS_B0)
        ofs_val[7:0] <= reg_req_i.wdata;
      else if (reg_req_i.addr == ASP_ADDR_OFS_B1)
        ofs_val[15:8] <= reg_req_i.wdata;
      else if (reg_req_i.addr == ASP_ADDR_OFS_B2)
        ofs_val[23:16] <= reg_req_i.wdata;
      else if (reg_req_i.addr == ASP_ADDR_GAIN_A)
        gain_val[7:0] <= reg_req_i.wdata;
      else if (reg_req_i.addr == ASP_ADDR_GAIN_B)
        gain_val[15:8] <= reg_req_i.wdata;
      else if (reg_req_i.addr == ASP_ADDR_PAT_B0)
        pat_val[7:0] <= reg_req_i.wdata;
      else if (reg_req_i.addr == ASP_ADDR_PAT_B1)
        pat_val[15:8] <= reg_req_i.wdata;
      else if (reg_req_i.addr == ASP_ADDR_PAT_B2)
        pat_val[23:16] <= reg_req_i.wdata;
      else if (reg_req_i.addr == ASP_ADDR_PAT_B3)
        pat_val[31:24] <= reg_req_i.wdata;
      else if (reg_req_i.addr == ASP_ADDR_MODE)
        fmt_sel <= asp_fmt_t'(reg_req_i.wdata[2:0]);
      else if (reg_req_i.addr == ASP_ADDR_AVG)
        avg_exp <= reg_req_i.wdata[ASP_EXP_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Offset, gain and saturation
  // ---------------------------------------------------------------
  logic signed [24:0] ofs_sum;
  logic signed [41:0] prod;
  logic signed [41:0] scaled;
  logic               clip_hi;
  logic               clip_lo;
  logic [23:0]        sat_code;

  always_comb
  begin
    // Two's complement in and out; sign extend before adding
    ofs_sum = $signed({sample_i.diff[23], sample_i.diff}) +
              $signed({ofs_val[23], ofs_val});
    prod    = ofs_sum * $signed({1'b0, gain_val});
    scaled  = prod >>> ASP_GAIN_SH;
    // Clamp instead of wrap; 16-bit format is a cut of this 24-bit code
    clip_hi = scaled > $signed({18'h00000, ASP_SAT_MAX});
    clip_lo = scaled < $signed({18'h3FFFF, ASP_SAT_MIN});
    if (clip_hi)
      sat_code = ASP_SAT_MAX;
    else if (clip_lo)
      sat_code = ASP_SAT_MIN;
    else
      sat_code = scaled[23:0];
  end

  // ---------------------------------------------------------------
  // Processed sample stage
  // ---------------------------------------------------------------
  logic              p_valid;
  logic [23:0]       p_code;
  logic [7:0]        p_cm;
  logic              p_sat;
  logic              take;

  assign take = convert_strobe_i && conv_ready_o;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      p_valid <= 1'b0;
      p_code  <= 24'h000000;
      p_cm    <= 8'h00;
      p_sat   <= 1'b0;
    end
    else
    begin
      p_valid <= take;
      if (take)
      begin
        p_code <= sat_code;
        p_cm   <= sample_i.cm;
        p_sat  <= sample_i.sat | clip_hi | clip_lo;
      end
    end
  end

  // ---------------------------------------------------------------
  // Block averaging filter
  // ---------------------------------------------------------------
  logic                  avg_on;
  logic [ASP_ACC_W-1:0]  acc;
  logic [ASP_CNT_W-1:0]  blk_cnt;
  logic                  or_acc;
  logic [ASP_CNT_W-1:0]  blk_last;
  logic [16:0]           blk_len;
  logic signed [39:0]    acc_next;
  logic signed [45:0]    acc_ext;
  logic signed [45:0]    avg_wide;
  logic                  or_next;
  logic                  blk_end;

  assign avg_on = (fmt_sel == ASP_FMT_AVG) &&
                  (avg_exp >= ASP_EXP_MIN) &&
                  (avg_exp <= ASP_EXP_MAX);

  always_comb
  begin
    blk_len  = 17'h00001 << avg_exp;
    blk_last = 16'(blk_len - 17'h00001);
    acc_next = $signed(acc) + $signed({{16{p_code[23]}}, p_code});
    or_next  = or_acc | p_sat;
    blk_end  = p_valid && avg_on && (blk_cnt == blk_last);
    // Sum times 2^6 over 2^N keeps constant input in the top 24 bits
    acc_ext  = {{6{acc_next[39]}}, acc_next};
    acc_ext  = acc_ext <<< ASP_AVG_EXT;
    avg_wide = acc_ext >>> avg_exp;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc     <= 40'h0000000000;
      blk_cnt <= 16'h0000;
      or_acc  <= 1'b0;
    end
    else if (cfg_wr || !avg_on || blk_end)
    begin
      // Fresh start for every block; no sample is shared
      acc     <= 40'h0000000000;
      blk_cnt <= 16'h0000;
      or_acc  <= 1'b0;
    end
    else if (p_valid)
    begin
      acc     <= acc_next;
      blk_cnt <= blk_cnt + 16'h0001;
      or_acc  <= or_next;
    end
  end

  // ---------------------------------------------------------------
  // Output word assembly
  // ---------------------------------------------------------------
  logic [31:0] fmt_word;
  logic        push;

  always_comb
  begin
    fmt_word = {p_code, 8'h00};
    if (avg_on)
    begin
      fmt_word[ASP_SYNC_BIT]      = 1'b1;
      fmt_word[ASP_OR_BIT]        = or_next;
      fmt_word[ASP_AVG_W-1:0]     = avg_wide[29:0];
    end
    else
    begin
      case (fmt_sel)
        ASP_FMT_D16CM: fmt_word = {p_code[23:8], p_cm, 8'h00};
        ASP_FMT_D24CM: fmt_word = {p_code, p_cm};
        ASP_FMT_PAT:   fmt_word = pat_val;
        default:       fmt_word = {p_code, 8'h00};
      endcase
    end
  end

  // Pattern rides the same stage as data, so timing matches
  assign push = p_valid && (!avg_on || blk_end);

  // ---------------------------------------------------------------
  // Two-entry output buffer
  // ---------------------------------------------------------------
  logic [31:0] skid_word;
  logic        skid_valid;
  logic [31:0] next_head;
  logic        next_head_v;
  logic [31:0] next_skid;
  logic        next_skid_v;
  logic        pop;
  logic [1:0]  next_occ;

  assign pop = out_valid_o && out_ready_i;

  always_comb
  begin
    next_head   = out_word_o;
    next_head_v = out_valid_o;
    next_skid   = skid_word;
    next_skid_v = skid_valid;
    case ({push, pop})
      2'b10:
      begin
        if (!out_valid_o)
        begin
          next_head   = fmt_word;
          next_head_v = 1'b1;
        end
        else
        begin
          next_skid   = fmt_word;
          next_skid_v = 1'b1;
        end
      end
      2'b01:
      begin
        if (skid_valid)
        begin
          next_head   = skid_word;
          next_skid_v = 1'b0;
        end
        else
          next_head_v = 1'b0;
      end
      2'b11:
      begin
        if (skid_valid)
        begin
          next_head = skid_word;
          next_skid = fmt_word;
        end
        else
          next_head = fmt_word;
      end
      default:
      begin
        next_head = out_word_o;
      end
    endcase
    // A sample in flight counts as occupied, so it always finds room
    next_occ = 2'({1'b0, next_head_v}) + 2'({1'b0, next_skid_v}) +
               2'({1'b0, take});
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_word_o   <= 32'h00000000;
      out_valid_o  <= 1'b0;
      skid_word    <= 32'h00000000;
      skid_valid   <= 1'b0;
      conv_ready_o <= 1'b0;
    end
    else
    begin
      out_word_o   <= next_head;
      out_valid_o  <= next_head_v;
      skid_word    <= next_skid;
      skid_valid   <= next_skid_v;
      conv_ready_o <= (next_occ < 2'h2);
    end
  end

  // ---------------------------------------------------------------
  // Register read-back
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 8'h00;
    else if (reg_req_i.rd)
    begin
      if (reg_req_i.addr == ASP_ADDR_OFS_B0)
        reg_rdata_o <= ofs_val[7:0];
      else if (reg_req_i.addr == ASP_ADDR_OFS_B1)
        reg_rdata_o <= ofs_val[15:8];
      else if (reg_req_i.addr == ASP_ADDR_OFS_B2)
        reg_rdata_o <= ofs_val[23:16];
      else if (reg_req_i.addr == ASP_ADDR_GAIN_A)
        reg_rdata_o <= gain_val[7:0];
      else if (reg_req_i.addr == ASP_ADDR_GAIN_B)
        reg_rdata_o <= gain_val[15:8];
      else if (reg_req_i.addr == ASP_ADDR_PAT_B0)
        reg_rdata_o <= pat_val[7:0];
      else if (reg_req_i.addr == ASP_ADDR_PAT_B1)
        reg_rdata_o <= pat_val[15:8];
      else if (reg_req_i.addr == ASP_ADDR_PAT_B2)
        reg_rdata_o <= pat_val[23:16];
      else if (reg_req_i.addr == ASP_ADDR_PAT_B3)
        reg_rdata_o <= pat_val[31:24];
      else if (reg_req_i.addr == ASP_ADDR_MODE)
        reg_rdata_o <= {5'h00, fmt_sel};
      else if (reg_req_i.addr == ASP_ADDR_AVG)
        reg_rdata_o <= {3'h0, avg_exp};
      else if (reg_req_i.addr == ASP_ADDR_STATUS)
        reg_rdata_o <= {avg_on, skid_valid, out_valid_o, blk_cnt[4:0]};
      else
        reg_rdata_o <= 8'h00;
    end
  end

endmodule : asp_post_proc

// >>> verification/asp_host_sink.sv
// Purpose: Host side consumer of output words
// Assumes: Ready changes only on the clock edge
// Notes:   Stall pattern comes from a shift register so it repeats per run
`timescale 1ns/10ps

module asp_host_sink
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // Handshake
  input  wire logic stall_i,
  output logic      out_ready_o
);
  logic [7:0] lfsr;

  // Ready is withheld at random, and fully while stall_i is high
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lfsr        <= 8'hA5;
      out_ready_o <= 1'b0;
    end
    else
    begin
      lfsr        <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      out_ready_o <= !stall_i && lfsr[0];
    end
  end
endmodule : asp_host_sink

// >>> verification/asp_post_proc_monitor.sv
// Purpose: Port level checks of the sample post-processing path
// Assumes: Register writes are the only way configuration changes
// Notes:   Word checks only judge words that arrive into an empty buffer
`timescale 1ns/10ps

module asp_post_proc_monitor
(
  // Clock and reset
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_n_i,
  // Design ports
  input  wire logic                      convert_strobe_i,
  input  wire asp_pkg::asp_sample_t      sample_i,
  input  wire logic                      conv_ready_o,
  input  wire asp_pkg::asp_reg_req_t     reg_req_i,
  input  wire logic [7:0]                reg_rdata_o,
  input  wire logic [31:0]               out_word_o,
  input  wire logic                      out_valid_o,
  input  wire logic                      out_ready_i
);
  import asp_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  logic       wr_seen;
  logic [2:0] mode;
  logic [4:0] nexp;
  logic [2:0] age;
  logic [31:0] pat;
  wire        take = convert_strobe_i && conv_ready_o;
  wire  [7:0] a    = reg_req_i.addr;
  wire        wr   = reg_req_i.wr;
  wire        rd0  = reg_req_i.rd && !wr && !wr_seen;
  wire        cfg  = wr && (a == ASP_ADDR_MODE || a == ASP_ADDR_AVG);

  // Shadow of the configuration, age counts cycles since a format or exponent write
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_seen <= 1'b0;
      mode    <= 3'h0;
      nexp    <= 5'h00;
      age     <= 3'h0;
      pat     <= ASP_PAT_RST;
    end
    else
    begin
      wr_seen <= wr_seen | wr;
      if (wr && a == ASP_ADDR_MODE)
        mode <= reg_req_i.wdata[2:0];
      if (wr && a == ASP_ADDR_AVG)
        nexp <= reg_req_i.wdata[4:0];
      if (wr && a >= ASP_ADDR_PAT_B0 && a <= ASP_ADDR_PAT_B3)
        pat[8*(a-ASP_ADDR_PAT_B0) +: 8] <= reg_req_i.wdata;
      age <= cfg ? 3'h0 : ((age == 3'h7) ? age : age + 3'h1);
    end
  end

  sequence s_fresh;
    $rose(out_valid_o) && $past(take, 2) && age >= 3'h4;
  endsequence

  a_gain_rst_lo:
    assert property (rd0 && a == ASP_ADDR_GAIN_A |=> reg_rdata_o == 8'h00)
    else $error("gain low byte reset value wrong");
  a_gain_rst_hi:
    assert property (rd0 && a == ASP_ADDR_GAIN_B |=> reg_rdata_o == 8'h80)
    else $error("gain high byte reset value wrong");
  a_ofs_rst_read:
    assert property (rd0 && a >= ASP_ADDR_OFS_B0 && a <= ASP_ADDR_OFS_B2
                     |=> reg_rdata_o == 8'h00)
    else $error("offset reset value wrong");
  a_pat_rst_read:
    assert property (rd0 && a == ASP_ADDR_PAT_B0 |=> reg_rdata_o == 8'h0F)
    else $error("pattern reset value wrong");
  a_avg_rst_read:
    assert property (rd0 && a == ASP_ADDR_AVG |=> reg_rdata_o == 8'h00)
    else $error("exponent reset value wrong");
  a_unmapped_read:
    assert property (reg_req_i.rd && a > ASP_ADDR_STATUS
                     |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_word_held:
    assert property (out_valid_o && !out_ready_i
                     |=> out_valid_o && $stable(out_word_o))
    else $error("stalled word changed");
  a_pattern_word:
    assert property (s_fresh ##0 mode == 3'h4 |-> out_word_o == pat)
    else $error("pattern word wrong");
  a_cm_append:
    assert property (s_fresh ##0 mode == 3'h2
                     |-> out_word_o[7:0] == $past(sample_i.cm, 2))
    else $error("common mode byte wrong");
  a_avg_sync:
    assert property (s_fresh ##0 mode == 3'h3 && nexp >= 5'h01 &&
                     nexp <= 5'h10 |-> out_word_o[ASP_SYNC_BIT])
    else $error("sync bit missing");
  a_or_flag:
    assert property (s_fresh ##0 mode == 3'h3 && nexp == 5'h01 &&
                     $past(sample_i.sat, 2) |-> out_word_o[ASP_OR_BIT])
    else $error("overrange bit missing");

  c_pattern: cover property (s_fresh ##0 mode == 3'h4);
  c_average: cover property (s_fresh ##0 mode == 3'h3);
  c_full:    cover property (!conv_ready_o);
endmodule : asp_post_proc_monitor

bind asp_post_proc asp_post_proc_monitor asp_post_proc_monitor_inst (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .convert_strobe_i(convert_strobe_i), .sample_i(sample_i),
  .conv_ready_o(conv_ready_o), .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o), .out_word_o(out_word_o),
  .out_valid_o(out_valid_o), .out_ready_i(out_ready_i));

// >>> verification/tb.sv
// Purpose: Self-checking bench of the sample post-processing path
// Assumes: Expected words follow offset, gain, clamp, then averaging
// Notes:   Short blocks only, so the longest exponents are not exercised
`timescale 1ns/10ps

module tb;
  import asp_pkg::*;
  logic         clk_sys_i = 1'b0;
  logic         rst_n_i   = 1'b0;
  logic         strobe    = 1'b0;
  logic         stall     = 1'b1;
  asp_sample_t  smp       = '0;
  asp_reg_req_t req       = '0;
  logic         rdy, cready, ovalid;
  logic [7:0]   rdata;
  logic [31:0]  oword, pat = ASP_PAT_RST;
  logic [23:0]  ofs  = 24'h000000;
  logic [15:0]  gain = 16'h8000;
  logic [2:0]   fmt  = 3'h0;
  logic [4:0]   nexp = 5'h00;
  logic [16:0]  cnt  = '0;
  logic signed [47:0] acc = '0;
  logic         orf  = 1'b0;
  logic [31:0]  expq[$];
  int           n_mismatch = 0;
  int           checked    = 0;
  logic [15:0]  rst_tab[13] = '{16'h1C00, 16'h1D80, 16'h1600, 16'h1700,
    16'h1800, 16'h200F, 16'h210F, 16'h225A, 16'h235A, 16'h2500, 16'h2400,
    16'h2600, 16'h3000};
  logic [2:0]   fmts[4] = '{3'h0, 3'h1, 3'h2, 3'h5};
  logic [4:0]   exps[5] = '{5'h01, 5'h02, 5'h03, 5'h00, 5'h11};

  always #25 clk_sys_i = ~clk_sys_i;

  asp_post_proc asp_post_proc_inst (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .convert_strobe_i(strobe), .sample_i(smp),
    .conv_ready_o(cready), .reg_req_i(req), .reg_rdata_o(rdata),
    .out_word_o(oword), .out_valid_o(ovalid), .out_ready_i(rdy));
  asp_host_sink asp_host_sink_inst (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .stall_i(stall), .out_ready_o(rdy));

  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic cmp(string what, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask : cmp

  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys_i);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys_i);
    #1 req.wr = 1'b0;
    if (a >= ASP_ADDR_OFS_B0 && a <= ASP_ADDR_OFS_B2)
      ofs[8*(a-ASP_ADDR_OFS_B0) +: 8] = d;
    if (a >= ASP_ADDR_PAT_B0 && a <= ASP_ADDR_PAT_B3)
      pat[8*(a-ASP_ADDR_PAT_B0) +: 8] = d;
    if (a == ASP_ADDR_GAIN_A)
      gain[7:0] = d;
    if (a == ASP_ADDR_GAIN_B)
      gain[15:8] = d;
    if (a == ASP_ADDR_MODE)
      fmt = d[2:0];
    if (a == ASP_ADDR_AVG)
      nexp = d[4:0];
    // A configuration write restarts the block
    if (a == ASP_ADDR_MODE || a == ASP_ADDR_AVG)
      {cnt, acc, orf} = '0;
  endtask : reg_wr

  task automatic reg_rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk_sys_i);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys_i);
    #1 req.rd = 1'b0;
    cmp("reg_rdata_o", {24'h0, e}, {24'h0, rdata});
  endtask : reg_rd

  function automatic logic [24:0] scale(logic [23:0] d);
    logic signed [43:0] p;
    p = (($signed(d) + $signed(ofs)) * $signed({1'b0, gain})) >>> 15;
    if (p > 44'sd8388607)
      return {1'b1, ASP_SAT_MAX};
    if (p < -44'sd8388608)
      return {1'b1, ASP_SAT_MIN};
    return {1'b0, p[23:0]};
  endfunction : scale

  task automatic send(logic [23:0] d, logic [7:0] cm, logic st);
    logic [24:0] r;
    r = scale(d);
    @(posedge clk_sys_i);
    #1 strobe = 1'b1;
    smp = '{diff: d, cm: cm, sat: st};
    do @(posedge clk_sys_i); while (cready !== 1'b1);
    #1 strobe = 1'b0;
    if (fmt == 3'h3 && nexp >= 5'h01 && nexp <= 5'h10)
    begin
      acc = acc + $signed(r[23:0]);
      orf = orf | r[24] | st;
      cnt = cnt + 17'h1;
      if (cnt == (1 << nexp))
      begin
        expq.push_back({1'b1, orf, 30'((acc * 64) >>> nexp)});
        {cnt, acc, orf} = '0;
      end
    end
    else if (fmt == 3'h1)
      expq.push_back({r[23:8], cm, 8'h00});
    else if (fmt == 3'h2)
      expq.push_back({r[23:0], cm});
    else if (fmt == 3'h4)
      expq.push_back(pat);
    else
      expq.push_back({r[23:0], 8'h00});
  endtask : send

  task automatic drain();
    for (int i = 0; i < 400 && expq.size() != 0; i++)
      @(posedge clk_sys_i);
    cmp("words left", 32'h0, expq.size());
  endtask : drain

  always @(posedge clk_sys_i)
    if (ovalid === 1'b1 && rdy === 1'b1)
      cmp("out_word_o", (expq.size() != 0) ? expq.pop_front() : ~oword,
          oword);

  // Generous bound: the sequence needs well under a millisecond
  initial
  begin
    #2ms;
    n_mismatch++;
    $display("BAD watchdog expected done seen timeout");
    final_report();
  end

  initial
  begin
    logic [23:0] v;
    int          k;
    void'($urandom(32'h05C328D2));
    repeat (20) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    foreach (rst_tab[i])
      reg_rd(rst_tab[i][15:8], rst_tab[i][7:0]);
    $display("test reset values done");
    send(24'h000100, 8'h11, 1'b0);
    send(24'h000200, 8'h22, 1'b0);
    repeat (3) @(posedge clk_sys_i);
    cmp("conv_ready_o", 32'h0, {31'h0, cready});
    #1 stall = 1'b0;
    drain();
    $display("test buffer full done");
    foreach (fmts[m])
    begin
      reg_wr(ASP_ADDR_MODE, {5'h00, fmts[m]});
      for (int b = 0; b < 3; b++)
        reg_wr(ASP_ADDR_OFS_B0 + 8'(b), 8'($urandom));
      reg_wr(ASP_ADDR_GAIN_A, 8'($urandom));
      reg_wr(ASP_ADDR_GAIN_B, 8'($urandom) | 8'h80);
      send(24'h7FFFFF, 8'h00, 1'b0);
      send(24'h800000, 8'hFF, 1'b0);
      repeat (6)
        send(24'($urandom), 8'($urandom), 1'($urandom));
      drain();
      $display("test format %0d done", fmts[m]);
    end
    reg_wr(ASP_ADDR_GAIN_A, 8'h00);
    reg_wr(ASP_ADDR_GAIN_B, 8'h80);
    for (int b = 0; b < 3; b++)
      reg_wr(ASP_ADDR_OFS_B0 + 8'(b), 8'h00);
    reg_wr(ASP_ADDR_MODE, 8'h03);
    foreach (exps[e])
    begin
      reg_wr(ASP_ADDR_AVG, {3'h0, exps[e]});
      k = (exps[e] >= 5'h01 && exps[e] <= 5'h10) ? (1 << exps[e]) : 2;
      repeat (4)
      begin
        v = 24'($urandom);
        repeat (k)
          send(v, 8'h00, 1'($urandom_range(3) == 0));
      end
      drain();
      $display("test exponent %0d done", exps[e]);
    end
    for (int b = 0; b < 4; b++)
      reg_wr(ASP_ADDR_PAT_B0 + 8'(b), 8'($urandom));
    reg_wr(ASP_ADDR_MODE, 8'h04);
    repeat (4)
      send(24'($urandom), 8'h00, 1'b0);
    drain();
    reg_rd(ASP_ADDR_PAT_B3, pat[31:24]);
    $display("test pattern done");
    final_report();
  end
endmodule : tb
